// *** quad_wiper_control.sv ***
// quad wiper controller: up/down pins, 2-wire slave and stored slots
// How it works
// - each 8-bit wiper code closes exactly one of 256 tap switches
// - code zero picks the low-end tap, all ones the high-end tap
// - at power-up every wiper loads its channel's default slot
// - select low enables stepping; select high means standby
// - each falling SCL while selected steps up or down by direction
// - the two channel-select pins pick channel 0 to 3
// - select rising with SCL and protect pin high stores to slot 0
// - select rising with SCL high but protect low stores nothing
// - select rising with SCL low keeps the wiper, no store
// - direction may change while selected; 2-wire disabled then
// - SDA changes only while SCL low except START and STOP
// - slave waits for START before answering anything
// - STOP, SDA rising with SCL high, ends every transfer
// - bytes travel most significant bit first
// - receiver pulls SDA low on the ninth clock to acknowledge
// - address byte: type id, strap bits, direction; ack on match only
// - in a write every byte after a matching address is acked
// - in a read send eight bits, go on after ack, stop on no ack
// - nonvolatile write runs a timed cycle ignoring 2-wire commands and stores; up/down steps still move the wiper
// - address polling is not acked while busy, acked when done
// - a valid up/down store starts the timed write at select rise
`include "quad_wiper_map.svh"
module quad_wiper_control #(
    // arbitrary type identifier value
    parameter logic [3:0]  TYPE_ID      = 4'hA,
    parameter int unsigned NV_WRITE_CYC = `NV_WRITE_NS / `CLK_PERIOD_NS
) (
    // clock and reset
    input  wire logic                     I_CLOCK,
    input  wire logic                     I_RST,
    // up/down interface; SCL is also the link clock
    input  wire logic                     I_SCL,
    input  wire logic                     I_CS_N,
    input  wire logic                     I_DIR_UP,
    input  wire logic                     I_CHANNEL_SEL_HI,
    input  wire logic                     I_CHANNEL_SEL_LO,
    input  wire logic                     I_WP_N,
    // 2-wire data pin, open drain
    input  wire logic                     I_SDA,
    output logic                          O_SDA,
    output logic                          O_SDA_OE,
    // address straps
    input  wire logic                     I_STRAP_ADDR_2,
    input  wire logic                     I_STRAP_ADDR_1,
    input  wire logic                     I_STRAP_ADDR_0,
    // wiper state
    output quad_wiper_pkg::pos_arr_t      O_WIPER_POS,
    output quad_wiper_pkg::tap_arr_t      O_TAP,
    output logic                          O_NV_BUSY
);
    import quad_wiper_pkg::*;

    // link domain: falling SCL while selected becomes a toggle event
    logic  lk_tgl_q;
    logic  lk_dir_q;
    chan_t lk_ch_q;

    always_ff @(negedge I_SCL or posedge I_RST) begin
        if (I_RST) begin
            lk_tgl_q <= 1'b0;
            lk_dir_q <= 1'b0;
            lk_ch_q  <= 2'h0;
        end else if (!I_CS_N) begin
            lk_tgl_q <= ~lk_tgl_q;
            lk_dir_q <= I_DIR_UP;
            lk_ch_q  <= {I_CHANNEL_SEL_HI, I_CHANNEL_SEL_LO};
        end
    end

    // pin synchronisers; stage one feeds only stage two
    logic [9:0] sync1_q;
    logic [9:0] sync2_q;
    logic [2:0] tgl_sync_q;

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            // SCL, SDA and select idle high: no false edge after reset
            sync1_q    <= 10'h007;
            sync2_q    <= 10'h007;
            tgl_sync_q <= 3'h0;
        end else begin
            sync1_q <= {I_STRAP_ADDR_2, I_STRAP_ADDR_1, I_STRAP_ADDR_0,
                        I_CHANNEL_SEL_HI, I_CHANNEL_SEL_LO, I_DIR_UP,
                        I_WP_N, I_CS_N, I_SDA, I_SCL};
            sync2_q <= sync1_q;
            // captured dir/channel stand a whole SCL period, far longer
            // than the toggle takes to cross
            tgl_sync_q <= {tgl_sync_q[1:0], lk_tgl_q};
        end
    end

    wire logic       scl_s   = sync2_q[0];
    wire logic       sda_s   = sync2_q[1];
    wire logic       cs_n_s  = sync2_q[2];
    wire logic       wp_s    = sync2_q[3];
    wire logic       dir_s   = sync2_q[4];
    wire chan_t      ch_s    = sync2_q[6:5];
    wire logic [2:0] strap_s = sync2_q[9:7];

    // previous levels for edge detection
    logic scl_p_q;
    logic sda_p_q;
    logic cs_p_q;

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            cs_p_q  <= 1'b1;
        end else begin
            scl_p_q <= scl_s;
            sda_p_q <= sda_s;
            cs_p_q  <= cs_n_s;
        end
    end

    wire logic scl_rise = scl_s && !scl_p_q;
    wire logic scl_fall = !scl_s && scl_p_q;
    // SDA moving while SCL stays high is only START or STOP
    wire logic start = scl_s && scl_p_q && sda_p_q && !sda_s;
    wire logic stop = scl_s && scl_p_q && !sda_p_q && sda_s;
    wire logic cs_rise = cs_n_s && !cs_p_q;
    wire logic cs_fall = !cs_n_s && cs_p_q;

    // nonvolatile write timer
    logic [31:0] busy_cnt_q;
    logic        busy;
    logic        ud_store;
    logic        i2c_nv_go;
    logic        nv_go;

    assign busy = busy_cnt_q != 32'h0000_0000;
    // store needs SCL and protect pin high; with SCL low it is a plain
    // deselect and the wiper simply keeps its value
    assign ud_store = cs_rise && scl_s && wp_s && !busy;
    assign nv_go = ud_store || i2c_nv_go;

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            busy_cnt_q <= 32'h0000_0000;
        end else if (nv_go && !busy) begin
            busy_cnt_q <= 32'(NV_WRITE_CYC);
        end else if (busy) begin
            busy_cnt_q <= busy_cnt_q - 32'h0000_0001;
        end
    end

    // stored slots; reset stands in for the retained contents
    wiper_t nv_q [4][4];
    wiper_t wpos [4];

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            for (int c = 0; c < 4; c++) begin
                for (int s = 0; s < 4; s++) begin
                    nv_q[c][s] <= `SLOT_INIT;
                end
            end
        end else if (ud_store) begin
            nv_q[ch_s][`DEF_SLOT] <= wpos[ch_s];
        end
    end

    // power-up recall one cycle after reset release
    logic recall_q;

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            recall_q <= 1'b1;
        end else begin
            recall_q <= 1'b0;
        end
    end

    // step sources: link toggle, or selection entered with SCL low
    // select already gates the toggle; gating it again here would drop
    // the last step when select rises just after the SCL fall
    wire logic  tgl_ev   = tgl_sync_q[2] ^ tgl_sync_q[1];
    wire logic  entry_ev = cs_fall && !scl_s;
    wire logic  step_ev  = tgl_ev || entry_ev;
    wire logic  step_up  = tgl_ev ? lk_dir_q : dir_s;
    wire chan_t step_ch  = tgl_ev ? lk_ch_q : ch_s;

    wiper_if wif[4] ();

    for (genvar g = 0; g < 4; g++) begin : g_ch
        assign wif[g].step     = step_ev && step_ch == 2'(g);
        assign wif[g].up       = step_up;
        assign wif[g].load     = recall_q;
        assign wif[g].load_val = nv_q[g][`DEF_SLOT];
        assign wpos[g]         = wif[g].pos;
        assign O_WIPER_POS[g]  = wif[g].pos;
        assign O_TAP[g]        = wif[g].tap;
        wiper_channel u_ch (
            .i_clk (I_CLOCK),
            .i_rst (I_RST),
            .w     (wif[g])
        );
    end

    // 2-wire slave
    link_state_t state_q;
    logic [3:0]  bit_q;
    logic [7:0]  shift_q;
    logic        rw_q;
    logic [1:0]  wbytes_q;
    chan_t       rd_ch_q;
    logic        sda_oe_q;
    logic        addr_ok;

    assign addr_ok = shift_q[`SA_TYPE_HI:`SA_TYPE_LO] == TYPE_ID &&
                     shift_q[`SA_DEV_HI:`SA_DEV_LO] == strap_s &&
                     !busy;
    assign i2c_nv_go = stop && cs_n_s && state_q != IDLE && !rw_q &&
                       wbytes_q == `WBYTES_NV;

    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            state_q  <= IDLE;
            bit_q    <= 4'h0;
            shift_q  <= 8'h00;
            rw_q     <= 1'b0;
            wbytes_q <= 2'h0;
            rd_ch_q  <= 2'h0;
            sda_oe_q <= 1'b0;
        end else if (!cs_n_s) begin
            state_q  <= IDLE;
            sda_oe_q <= 1'b0;
        end else if (start) begin
            state_q  <= ADDR;
            bit_q    <= 4'h0;
            wbytes_q <= 2'h0;
            rd_ch_q  <= 2'h0;
            sda_oe_q <= 1'b0;
        end else if (stop) begin
            state_q  <= IDLE;
            sda_oe_q <= 1'b0;
        end else begin
            unique case (state_q)
                IDLE: begin
                    sda_oe_q <= 1'b0;
                end
                ADDR, WDATA: begin
                    if (scl_rise) begin
                        shift_q <= {shift_q[6:0], sda_s};
                        bit_q   <= bit_q + 4'h1;
                    end else if (scl_fall && bit_q == `BYTE_DONE) begin
                        if (state_q == WDATA) begin
                            state_q  <= ACK_W;
                            sda_oe_q <= 1'b1;
                            if (wbytes_q != `WBYTES_NV) begin
                                wbytes_q <= wbytes_q + 2'h1;
                            end
                        end else if (addr_ok) begin
                            state_q  <= ACK_A;
                            sda_oe_q <= 1'b1;
                            rw_q     <= shift_q[`SA_RW];
                        end else begin
                            // wrong address or busy: no ack, wait
                            state_q <= IDLE;
                        end
                    end
                end
                ACK_A: begin
                    if (scl_fall) begin
                        bit_q <= 4'h0;
                        if (rw_q) begin
                            state_q  <= RDATA;
                            shift_q  <= wpos[rd_ch_q];
                            sda_oe_q <= ~wpos[rd_ch_q][7];
                        end else begin
                            state_q  <= WDATA;
                            sda_oe_q <= 1'b0;
                        end
                    end
                end
                ACK_W: begin
                    if (scl_fall) begin
                        state_q  <= WDATA;
                        bit_q    <= 4'h0;
                        sda_oe_q <= 1'b0;
                    end
                end
                RDATA: begin
                    if (scl_fall) begin
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == `LAST_TX_BIT) begin
                            state_q  <= RACK;
                            sda_oe_q <= 1'b0;
                        end else begin
                            shift_q  <= {shift_q[6:0], 1'b0};
                            sda_oe_q <= ~shift_q[6];
                        end
                    end
                end
                RACK: begin
                    if (scl_rise && sda_s) begin
                        state_q <= IDLE;
                    end else if (scl_fall) begin
                        state_q  <= RDATA;
                        bit_q    <= 4'h0;
                        rd_ch_q  <= rd_ch_q + 2'h1;
                        shift_q  <= wpos[rd_ch_q + 2'h1];
                        sda_oe_q <= ~wpos[rd_ch_q + 2'h1][7];
                    end
                end
                default: begin
                    state_q  <= IDLE;
                    sda_oe_q <= 1'b0;
                end
            endcase
        end
    end

    // open drain: the pin only ever pulls low
    assign O_SDA     = 1'b0;
    assign O_SDA_OE  = sda_oe_q;
    assign O_NV_BUSY = busy;

    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);

    recall_load_a:
    assert property (recall_q |=> wpos[0] == $past(nv_q[0][0]) &&
        wpos[3] == $past(nv_q[3][0])) else $error("recall missed");
    store_slot_a:
    assert property (ud_store |=>
        nv_q[$past(ch_s)][0] == $past(wpos[ch_s]) && busy)
        else $error("store missed");
    no_store_a:
    assert property (cs_rise && !busy && !wp_s && !i2c_nv_go |=> !busy)
        else $error("store despite protect");
    deselect_a:
    assert property (cs_rise && !busy && !scl_s && !i2c_nv_go |=> !busy)
        else $error("store with SCL low");
    select_quiet_a:
    assert property (!cs_n_s |=> !sda_oe_q && state_q == IDLE)
        else $error("2-wire active while selected");
    wait_start_a:
    assert property (state_q == IDLE && !start |=> state_q == IDLE)
        else $error("left idle without START");
    msb_first_a:
    assert property (state_q == ADDR && scl_rise && cs_n_s && !start
        && !stop |=> shift_q[0] == $past(sda_s)) else $error("bit order");
    addr_ack_a:
    assert property (state_q == ADDR && scl_fall && bit_q == `BYTE_DONE
        && cs_n_s && addr_ok |=> sda_oe_q && state_q == ACK_A)
        else $error("address not acked");
    busy_nack_a:
    assert property (state_q == ADDR && scl_fall && bit_q == `BYTE_DONE
        && busy |=> !sda_oe_q) else $error("acked while busy");
    busy_len_a:
    assert property (nv_go && !busy |=>
        busy_cnt_q == 32'(NV_WRITE_CYC)) else $error("write cycle length");
    read_nack_a:
    assert property (state_q == RACK && scl_rise && sda_s && cs_n_s
        && !start && !stop |=> state_q == IDLE) else $error("sent on nack");

    cover property (ud_store);
    cover property (state_q == RACK && scl_fall && cs_n_s);
    cover property (busy && state_q == ADDR && scl_fall);
    cover property (step_ev && step_up);
endmodule

// *** quad_wiper_map.svh ***
// register layout, field positions, reset values and timing counts
`ifndef QUAD_WIPER_MAP_SVH
`define QUAD_WIPER_MAP_SVH
`define CLK_PERIOD_NS 25
`define NV_WRITE_NS   5000000
`define SLOT_INIT     8'h80
`define WIPER_RST     8'h00
`define WIPER_MAX     8'hFF
`define DEF_SLOT      2'h0
`define SA_TYPE_HI    7
`define SA_TYPE_LO    4
`define SA_DEV_HI     3
`define SA_DEV_LO     1
`define SA_RW         0
`define BYTE_DONE     4'h8
`define LAST_TX_BIT   4'h7
`define WBYTES_NV     2'h2
`endif

// *** quad_wiper_pkg.sv ***
// types shared by the wiper controller and its channels
package quad_wiper_pkg;
    typedef logic [7:0]   wiper_t;
    typedef logic [1:0]   chan_t;
    typedef logic [255:0] tap_t;
    typedef wiper_t [3:0] pos_arr_t;
    typedef tap_t   [3:0] tap_arr_t;
    typedef enum logic [2:0] {
        IDLE  = 3'h0,
        ADDR  = 3'h1,
        ACK_A = 3'h3,
        WDATA = 3'h2,
        ACK_W = 3'h6,
        RDATA = 3'h7,
        RACK  = 3'h5
    } link_state_t;
endpackage

// *** wiper_if.sv ***
// per-channel wiper control signals between controller and channel
interface wiper_if;
    import quad_wiper_pkg::*;
    logic   step;
    logic   up;
    logic   load;
    wiper_t load_val;
    wiper_t pos;
    tap_t   tap;
    modport chan (input step, up, load, load_val, output pos, tap);
    modport ctrl (output step, up, load, load_val, input pos, tap);
endinterface

// *** wiper_channel.sv ***
// one wiper position counter with its tap decoder
`include "quad_wiper_map.svh"
module wiper_channel (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // control from the controller
    wiper_if.chan     w
);
    import quad_wiper_pkg::*;

    wiper_t pos_q;
    tap_t   tap_q;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pos_q <= `WIPER_RST;
        end else if (w.load) begin
            pos_q <= w.load_val;
        end else if (w.step) begin
            // ends hold rather than wrap round the array
            if (w.up && pos_q != `WIPER_MAX) begin
                pos_q <= pos_q + 8'h01;
            end else if (!w.up && pos_q != `WIPER_RST) begin
                pos_q <= pos_q - 8'h01;
            end
        end
    end

    // code 0 closes the switch at the low end, all ones the high end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tap_q <= 256'h1;
        end else begin
            tap_q <= tap_t'(1) << pos_q;
        end
    end

    assign w.pos = pos_q;
    assign w.tap = tap_q;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    tap_onehot_a:
    assert property ($onehot(tap_q)) else $error("tap not one-hot");
    tap_position_a:
    assert property (1 |=> tap_q[$past(pos_q)]) else $error("wrong tap");
    wiper_sat_a:
    assert property (w.step && w.up && !w.load && pos_q == `WIPER_MAX
        |=> pos_q == `WIPER_MAX) else $error("wiper wrapped");
    step_up_a:
    assert property (w.step && w.up && !w.load && pos_q != `WIPER_MAX
        |=> pos_q == $past(pos_q) + 8'h01) else $error("step up lost");
endmodule

// *** quad_wiper_host.sv ***
// host model: drives the step pins and masters the 2-wire bus
module quad_wiper_host (
    // step and bus pins
    output logic       o_scl,
    output logic       o_sda_oe,
    output logic       o_cs_n,
    output logic       o_dir_up,
    output logic [1:0] o_chan,
    // resolved data line
    input  wire logic  i_sda
);
    timeunit 1ns;
    timeprecision 1ps;
    // slot-select bits are never written, so stores always hit slot 0
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
        o_cs_n = 1'b1;
        o_dir_up = 1'b0;
        o_chan = 2'd0;
    end
    // data moves mid-way through SCL low, a clock clear of either edge
    task automatic bit_io(input logic b, output logic r);
        #40 o_sda_oe = ~b;
        #40 o_scl = 1'b1;
        #70 r = i_sda;
        #10 o_scl = 1'b0;
    endtask
    task automatic start();
        o_sda_oe = 1'b0;
        o_scl = 1'b1;
        #80 o_sda_oe = 1'b1;
        #80 o_scl = 1'b0;
    endtask
    task automatic stop();
        #40 o_sda_oe = 1'b1;
        #40 o_scl = 1'b1;
        #80 o_sda_oe = 1'b0;
        #160;
    endtask
    task automatic xfer(input logic [7:0] tx, input logic mack,
                        output logic [7:0] rx, output logic sack);
        for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
        bit_io(mack, sack);
    endtask
    // select only while SCL is high, so entry gives no stray step
    task automatic select();
        o_scl = 1'b1;
        #80 o_cs_n = 1'b0;
        #80;
    endtask
    // discouraged entry: select while SCL is low, which gives one step
    task automatic enter_low();
        o_scl = 1'b0;
        #80 o_cs_n = 1'b0;
        #80;
    endtask
    task automatic steps(input logic [1:0] c, input logic up, input int n);
        o_chan = c;
        o_dir_up = up;
        repeat (n) begin
            o_scl = 1'b1;
            #80 o_scl = 1'b0;
            #80;
        end
    endtask
    task automatic deselect(input logic hi);
        if (hi) begin
            o_scl = 1'b1;
            #1000;
        end
        o_cs_n = 1'b1;
        #200 o_scl = 1'b1;
        #200;
    endtask
endmodule

// *** quad_wiper_control_bench.sv ***
// self-checking bench for the quad wiper controller
module quad_wiper_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import quad_wiper_pkg::*;
    // arbitrary type identifier
    localparam logic [3:0] ID = 4'hA;
    localparam int NV = 200;
    typedef struct {string what; logic is_bit; logic [7:0] val;} note_t;
    logic clk, rst, wp_n, sda, scl, host_oe, cs_n, dir_up, o_sda, o_oe;
    logic busy, ack;
    logic [1:0] chan;
    logic [2:0] strap;
    logic [7:0] rx, seen;
    pos_arr_t pos;
    tap_arr_t tap;
    wiper_t exp_pos [4];
    note_t exp_q [$];
    note_t nt;
    event seen_ev;
    int err_count, check_count;
    int unsigned seed, n;
    // open-drain wire with pull-up
    assign sda = (o_oe ? o_sda : 1'b1) && !host_oe;
    quad_wiper_control #(.TYPE_ID(ID), .NV_WRITE_CYC(NV)) DUT (
        .I_CLOCK(clk), .I_RST(rst), .I_SCL(scl), .I_CS_N(cs_n),
        .I_DIR_UP(dir_up), .I_CHANNEL_SEL_HI(chan[1]),
        .I_CHANNEL_SEL_LO(chan[0]), .I_WP_N(wp_n), .I_SDA(sda),
        .O_SDA(o_sda), .O_SDA_OE(o_oe), .I_STRAP_ADDR_2(strap[2]),
        .I_STRAP_ADDR_1(strap[1]), .I_STRAP_ADDR_0(strap[0]),
        .O_WIPER_POS(pos), .O_TAP(tap), .O_NV_BUSY(busy));
    quad_wiper_host host (.o_scl(scl), .o_sda_oe(host_oe), .o_cs_n(cs_n),
        .o_dir_up(dir_up), .o_chan(chan), .i_sda(sda));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic note(input string w, input logic b, input logic [7:0] v);
        exp_q.push_back('{w, b, v});
    endtask
    // the #1 keeps two results in one time step from merging
    task automatic post(input logic [7:0] v);
        seen = v;
        -> seen_ev;
        #1;
    endtask
    task automatic cmp_byte(input string w, input logic [7:0] e, s);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", w, e, s);
        end
    endtask
    task automatic cmp_bit(input string w, input logic e, s);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("[FAIL] %s expected %b seen %b", w, e, s);
        end
    endtask
    initial forever begin
        @(seen_ev);
        if (exp_q.size() == 0) begin
            err_count++;
            $display("[FAIL] result expected none seen %h", seen);
        end else begin
            nt = exp_q.pop_front();
            if (nt.is_bit)
                cmp_bit(nt.what, nt.val[0], seen[0]);
            else
                cmp_byte(nt.what, nt.val, seen);
        end
    end
    function automatic wiper_t nxt(wiper_t p, logic up, int k);
        repeat (k)
            if (up && p != 8'hFF) p++;
            else if (!up && p != 8'h00) p--;
        return p;
    endfunction
    task automatic chk_pos(input int c);
        repeat (8) @(negedge clk);
        note("position", 1'b0, exp_pos[c]);
        post(pos[c]);
        note("tap", 1'b1, 8'h01);
        post({7'h0, tap[c] === (tap_t'(1) << exp_pos[c])});
    endtask
    task automatic chk_busy(input logic e);
        note("busy", 1'b1, {7'h0, e});
        post({7'h0, busy});
    endtask
    // e high means an acknowledge is expected
    task automatic poll(input logic [3:0] id, input logic [2:0] sa,
                        input logic rw, input logic e);
        host.start();
        host.xfer({id, sa, rw}, 1'b1, rx, ack);
        note("address ack", 1'b1, {7'h0, ~e});
        post({7'h0, ack});
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #1_000_000;
        err_count++;
        $display("[FAIL] run expected finish seen timeout");
        summarize();
    end
    initial begin
        err_count = 0;
        check_count = 0;
        rst = 1'b1;
        wp_n = 1'b1;
        seed = $urandom(32'hcdd9);
        strap = 3'($urandom);
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (6) @(negedge clk);
        for (int c = 0; c < 4; c++) begin
            exp_pos[c] = 8'h80;
            chk_pos(c);
        end
        host.select();
        for (int k = 0; k < 8; k++) begin
            n = 1 + $urandom % 5;
            host.steps(2'(k), k[2], n);
            exp_pos[k % 4] = nxt(exp_pos[k % 4], k[2], n);
            chk_pos(k % 4);
        end
        host.steps(2'd0, 1'b0, 140);
        exp_pos[0] = 8'h00;
        chk_pos(0);
        host.steps(2'd0, 1'b1, 260);
        exp_pos[0] = 8'hFF;
        chk_pos(0);
        host.deselect(1'b0);
        chk_busy(1'b0);
        host.steps(2'd0, 1'b0, 3);
        chk_pos(0);
        @(negedge clk);
        wp_n = 1'b0;
        host.select();
        host.deselect(1'b1);
        chk_busy(1'b0);
        @(negedge clk);
        wp_n = 1'b1;
        host.select();
        host.steps(2'd0, 1'b0, 1);
        exp_pos[0] = 8'hFE;
        host.deselect(1'b1);
        chk_busy(1'b1);
        poll(ID, strap, 1'b1, 1'b0);
        host.stop();
        repeat (NV) @(negedge clk);
        chk_busy(1'b0);
        poll(ID, strap, 1'b0, 1'b1);
        host.stop();
        chk_pos(0);
        poll(ID ^ 4'h5, strap, 1'b0, 1'b0);
        host.stop();
        poll(ID, strap ^ 3'h1, 1'b0, 1'b0);
        host.stop();
        host.xfer({ID, strap, 1'b0}, 1'b1, rx, ack);
        note("ack without start", 1'b1, 8'h01);
        post({7'h0, ack});
        host.stop();
        poll(ID, strap, 1'b0, 1'b1);
        for (int b = 0; b < 2; b++) begin
            host.xfer(8'($urandom), 1'b1, rx, ack);
            note("data ack", 1'b1, 8'h00);
            post({7'h0, ack});
        end
        host.stop();
        repeat (6) @(negedge clk);
        chk_busy(1'b1);
        poll(ID, strap, 1'b0, 1'b0);
        host.stop();
        repeat (NV) @(negedge clk);
        host.select();
        host.steps(2'd3, 1'b1, 0);
        poll(ID, strap, 1'b0, 1'b0);
        host.deselect(1'b0);
        exp_pos[3] = nxt(exp_pos[3], 1'b1, 10);
        chk_pos(3);
        host.steps(2'd1, 1'b0, 0);
        host.enter_low();
        host.deselect(1'b0);
        exp_pos[1] = nxt(exp_pos[1], 1'b0, 1);
        chk_pos(1);
        poll(ID, strap, 1'b1, 1'b1);
        for (int b = 0; b < 5; b++) begin
            host.xfer(8'hFF, b == 4, rx, ack);
            note("read byte", 1'b0, exp_pos[b % 4]);
            post(rx);
        end
        host.stop();
        if (exp_q.size() != 0)
            err_count++;
        summarize();
    end
endmodule
